// file: logic/ipl_params.svh
`ifndef IPL_PARAMS_SVH
`define IPL_PARAMS_SVH

// Register offsets (byte addresses on the configuration port)
`define IPL_ADDR_INT_CFG      7'h7D
// The key register has no known offset; chosen as a parameterised default
`define IPL_ADDR_KEY          7'h7E

// Reset values
`define IPL_INT_CFG_RESET     8'h02
`define IPL_KEY_RESET         8'h85

// Key values
`define IPL_KEY_FULL          8'h85
`define IPL_KEY_SINGLE        8'h86
// Value left behind once a single-write key has been used up
`define IPL_KEY_SPENT         8'h00

// Interrupt configuration field positions
`define IPL_BIT_POLARITY      0
`define IPL_BIT_TRISTATE      1
`define IPL_BIT_GP_SELECT     2
`define IPL_INT_CFG_USED      3'h7

`endif

// file: logic/ipl_pkg.sv
package ipl_pkg;
    typedef enum logic [1:0] {
        IPL_PROTECTED,
        IPL_FULL_OPEN,
        IPL_SINGLE_OPEN
    } ipl_lock_e;
endpackage

// file: logic/ipl_pin_drive.sv
`timescale 1ns/1ps
`include "ipl_params.svh"

// ----------------------------------------------------------------------------
// Interrupt pin driver
// ----------------------------------------------------------------------------
module ipl_pin_drive
    import ipl_pkg::*;
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_rstn,
    input  wire logic [2:0] i_cfg,
    input  wire logic       i_irq_active,
    output logic            o_pin,
    output logic            o_pin_oe
);

    logic polarity;
    logic tristate;
    logic gp_output_select;
    logic next_pin;
    logic next_oe;

    assign polarity         = i_cfg[`IPL_BIT_POLARITY];
    assign tristate         = i_cfg[`IPL_BIT_TRISTATE];
    assign gp_output_select = i_cfg[`IPL_BIT_GP_SELECT];

    // Level and enable choice; general purpose mode always drives
    always_comb begin
        if (gp_output_select) begin
            next_pin = polarity;
            next_oe  = 1'b1;
        end else begin
            next_pin = i_irq_active ? polarity : ~polarity;
            next_oe  = tristate ? i_irq_active : 1'b1;
        end
    end

    // Registered so the pin never glitches on config writes
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_pin    <= 1'b1;
            o_pin_oe <= 1'b0;
        end else begin
            o_pin    <= next_pin;
            o_pin_oe <= next_oe;
        end
    end

endmodule // ipl_pin_drive

// file: logic/ipl_regs.sv
// Operation
// - Tristate bit zero always drives pin
// - Interrupt config resets to 0x02
// - Other key values protect other registers
// - Key 0x85 permits all writes
// - Key 0x86 permits one write only
// - Key resets 0x85, always writable
`timescale 1ns/1ps
`include "ipl_params.svh"

// ----------------------------------------------------------------------------
// Interrupt pin configuration and write lock registers
// ----------------------------------------------------------------------------
module ipl_regs
    import ipl_pkg::*;
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_rstn,
    input  wire logic       i_wr_en,
    input  wire logic       i_rd_en,
    input  wire logic [6:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_irq_active,
    output logic [7:0]      o_rdata,
    output logic            o_rd_valid,
    output logic            o_wr_other,
    output logic            o_irq_pin,
    output logic            o_irq_pin_oe,
    output logic [1:0]      o_lock_mode
);

    // ------------------------------------------------------------------------
    // Storage and decode
    // ------------------------------------------------------------------------
    logic [2:0] int_cfg;
    logic [7:0] write_lock_key;
    ipl_lock_e  lock_mode;
    logic       hit_cfg;
    logic       hit_key;
    logic       wr_allowed;
    logic       wr_other;
    logic       cfg_polarity;

    assign hit_cfg  = (i_addr == `IPL_ADDR_INT_CFG);
    assign hit_key  = (i_addr == `IPL_ADDR_KEY);
    assign wr_other = i_wr_en && !hit_key;

    // Key decoding into the three protection modes
    always_comb begin
        case (write_lock_key)
            `IPL_KEY_FULL:   lock_mode = IPL_FULL_OPEN;
            `IPL_KEY_SINGLE: lock_mode = IPL_SINGLE_OPEN;
            default:         lock_mode = IPL_PROTECTED;
        endcase
    end

    assign wr_allowed = (lock_mode != IPL_PROTECTED);

    // ------------------------------------------------------------------------
    // Register updates
    // ------------------------------------------------------------------------
    // Key register; a consumed single key reads back as zero afterward
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            write_lock_key <= `IPL_KEY_RESET;
        end else if (i_wr_en && hit_key) begin
            write_lock_key <= i_wdata;
        end else if (wr_other && lock_mode == IPL_SINGLE_OPEN) begin
            write_lock_key <= `IPL_KEY_SPENT;
        end
    end

    // Interrupt config; any write to another register spends a single key
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            int_cfg <= 3'(`IPL_INT_CFG_RESET);
        end else if (i_wr_en && hit_cfg && wr_allowed) begin
            int_cfg <= i_wdata[2:0] & `IPL_INT_CFG_USED;
        end
    end

    // Write strobe for registers elsewhere in the device
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_wr_other <= 1'b0;
        end else begin
            o_wr_other <= wr_other && !hit_cfg && wr_allowed;
        end
    end

    // Read path; unmapped addresses read zero, unused bits read zero
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata    <= 8'h00;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= i_rd_en;
            if (i_rd_en && hit_cfg) begin
                o_rdata <= {5'h00, int_cfg};
            end else if (i_rd_en && hit_key) begin
                o_rdata <= write_lock_key;
            end else if (i_rd_en) begin
                o_rdata <= 8'h00;
            end
        end
    end

    // Mode visible to the rest of the device
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_lock_mode <= 2'(IPL_FULL_OPEN);
        end else begin
            o_lock_mode <= 2'(lock_mode);
        end
    end

    // ------------------------------------------------------------------------
    // Pin driver
    // ------------------------------------------------------------------------
    ipl_pin_drive u_pin (
        .i_ref_clk    (i_ref_clk),
        .i_rstn       (i_rstn),
        .i_cfg        (int_cfg),
        .i_irq_active (i_irq_active),
        .o_pin        (o_irq_pin),
        .o_pin_oe     (o_irq_pin_oe)
    );

    // ------------------------------------------------------------------------
    // Checks: write lock
    // ------------------------------------------------------------------------
    // protected config write ignored
    chk_protect_blocks: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (i_wr_en && hit_cfg && lock_mode == IPL_PROTECTED) |=> $stable(int_cfg))
        else $error("config changed while protected");

    chk_other_blocked: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (i_wr_en && !hit_key && lock_mode == IPL_PROTECTED) |=> !o_wr_other)
        else $error("write passed while protected");

    chk_mode_out: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (write_lock_key != `IPL_KEY_FULL && write_lock_key != `IPL_KEY_SINGLE)
        |=> o_lock_mode == 2'(IPL_PROTECTED))
        else $error("protected mode not reported");

    chk_full_open: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (i_wr_en && hit_cfg && write_lock_key == `IPL_KEY_FULL)
        |=> int_cfg == 3'($past(i_wdata)) && write_lock_key == `IPL_KEY_FULL)
        else $error("full unlock write lost");

    chk_full_other: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (i_wr_en && !hit_key && !hit_cfg && write_lock_key == `IPL_KEY_FULL)
        |=> o_wr_other && write_lock_key == `IPL_KEY_FULL)
        else $error("full unlock strobe lost");

    chk_single_spent: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (wr_other && lock_mode == IPL_SINGLE_OPEN) |=> lock_mode == IPL_PROTECTED)
        else $error("single unlock not re-protected");

    chk_single_cfg: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (i_wr_en && hit_cfg && write_lock_key == `IPL_KEY_SINGLE)
        |=> int_cfg == 3'($past(i_wdata)))
        else $error("single unlock write lost");

    chk_key_writable: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (i_wr_en && hit_key) |=> write_lock_key == $past(i_wdata))
        else $error("key write ignored");

    chk_key_holds: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (!i_wr_en) |=> $stable(write_lock_key))
        else $error("key changed without a write");

    // ------------------------------------------------------------------------
    // Checks: reset, read-back and pin
    // ------------------------------------------------------------------------
    // Polarity kept as a whole net so the past-value checks sample a plain signal
    assign cfg_polarity = int_cfg[`IPL_BIT_POLARITY];

    chk_reset_value: assert property (@(posedge i_ref_clk)
        $rose(i_rstn) |-> int_cfg == 3'(`IPL_INT_CFG_RESET)
        && write_lock_key == `IPL_KEY_RESET)
        else $error("reset values wrong");

    chk_cfg_readback: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (i_rd_en && hit_cfg) |=> o_rd_valid && o_rdata == 8'($past(int_cfg)))
        else $error("config read back wrong");

    chk_drive_always: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (!int_cfg[`IPL_BIT_TRISTATE] && !int_cfg[`IPL_BIT_GP_SELECT])[*2] |-> o_irq_pin_oe)
        else $error("pin floated with tristate off");

    chk_float_idle: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (int_cfg[`IPL_BIT_TRISTATE] && !int_cfg[`IPL_BIT_GP_SELECT] && !i_irq_active)
        |=> !o_irq_pin_oe)
        else $error("pin driven while idle");

    chk_irq_drive: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (!int_cfg[`IPL_BIT_GP_SELECT] && i_irq_active)
        |=> o_irq_pin_oe && o_irq_pin == $past(cfg_polarity))
        else $error("active interrupt not driven");

    chk_gp_level: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (int_cfg[`IPL_BIT_GP_SELECT])[*2] |-> o_irq_pin_oe
        && o_irq_pin == $past(cfg_polarity))
        else $error("general purpose level wrong");

endmodule // ipl_regs

// file: verification/ipl_host_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Host side of the shared interrupt line
// ----------------------------------------------------------------------------
module ipl_host_model (
    input  wire logic i_pin,
    input  wire logic i_pin_oe,
    output logic      o_line
);
    // Board pull-up holds the wired line high whenever no source drives it
    assign o_line = i_pin_oe ? i_pin : 1'b1;
endmodule // ipl_host_model

// file: verification/tb_top.sv
`timescale 1ns/1ps
`include "ipl_params.svh"

module tb_top;
    localparam logic [6:0] CFG_A = `IPL_ADDR_INT_CFG;
    localparam logic [6:0] KEY_A = `IPL_ADDR_KEY;
    localparam logic [6:0] UNM_A = 7'h10;
    logic       i_ref_clk, i_rstn, i_wr_en, i_rd_en, i_irq_active;
    logic [6:0] i_addr;
    logic [7:0] i_wdata, o_rdata;
    logic       o_rd_valid, o_wr_other, o_irq_pin, o_irq_pin_oe, line;
    logic [1:0] o_lock_mode;
    logic [7:0] keys [4] = '{8'h00, 8'h84, 8'h87, 8'hFF};
    int         err_count, n_compared;

    ipl_regs dut (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_wr_en(i_wr_en),
        .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_irq_active(i_irq_active), .o_rdata(o_rdata), .o_rd_valid(o_rd_valid),
        .o_wr_other(o_wr_other), .o_irq_pin(o_irq_pin), .o_irq_pin_oe(o_irq_pin_oe),
        .o_lock_mode(o_lock_mode));
    ipl_host_model host (.i_pin(o_irq_pin), .i_pin_oe(o_irq_pin_oe), .o_line(line));

    // ------------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------------
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Strobe held for exactly one sampling edge
    task wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_wr_en <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr_en <= 1'b0;
        #1;
    endtask

    task rd(input logic [6:0] a, input logic [7:0] exp);
        @(posedge i_ref_clk);
        i_rd_en <= 1'b1;
        i_addr  <= a;
        @(posedge i_ref_clk);
        i_rd_en <= 1'b0;
        #1;
        chk({7'h0, o_rd_valid}, 8'h01);
        chk(o_rdata, exp);
    endtask

    // Expected value packs {enable, line level seen by the host}
    task pin(input logic irq, input logic [7:0] exp);
        @(posedge i_ref_clk);
        i_irq_active <= irq;
        repeat (2) @(posedge i_ref_clk);
        #1;
        chk({6'h0, o_irq_pin_oe, line}, exp);
    endtask

    task results;
        $display("compared=%0d mismatches=%0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Clock, watchdog and tests
    // ------------------------------------------------------------------------
    initial begin
        i_ref_clk = 1'b0;
        forever #20 i_ref_clk = ~i_ref_clk;
    end

    // Whole sequence needs well under 500 cycles
    initial begin
        repeat (3000) @(posedge i_ref_clk);
        err_count++;
        results();
    end

    initial begin
        {i_rstn, i_wr_en, i_rd_en, i_irq_active} = 4'h0;
        i_addr  = 7'h00;
        i_wdata = 8'h00;
        repeat (12) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        rd(CFG_A, 8'h02);
        rd(KEY_A, 8'h85);
        chk({6'h0, o_lock_mode}, 8'h01);
        pin(1'b0, 8'h01);
        pin(1'b1, 8'h02);
        wr(CFG_A, 8'h00);
        pin(1'b0, 8'h03);
        // Upper bits must be dropped on write
        wr(CFG_A, 8'hF9);
        rd(CFG_A, 8'h01);
        pin(1'b1, 8'h03);
        pin(1'b0, 8'h02);
        wr(CFG_A, 8'hFC);
        pin(1'b1, 8'h02);
        wr(CFG_A, 8'h05);
        pin(1'b0, 8'h03);
        wr(UNM_A, 8'hAA);
        chk({7'h0, o_wr_other}, 8'h01);
        // Four locking keys, including both range edges
        foreach (keys[i]) begin
            wr(KEY_A, keys[i]);
            rd(KEY_A, keys[i]);
            wr(CFG_A, 8'h00);
            rd(CFG_A, 8'h05);
            wr(UNM_A, 8'hAA);
            chk({7'h0, o_wr_other}, 8'h00);
            chk({6'h0, o_lock_mode}, 8'h00);
        end
        // Single key allows one write; a second write without re-entering the key is blocked
        wr(KEY_A, `IPL_KEY_SINGLE);
        wr(CFG_A, 8'h01);
        chk({7'h0, o_wr_other}, 8'h00);
        rd(CFG_A, 8'h01);
        rd(KEY_A, 8'h00);
        wr(CFG_A, 8'h02);
        rd(CFG_A, 8'h01);
        wr(KEY_A, `IPL_KEY_SINGLE);
        // Reading the key must not use it up
        rd(KEY_A, 8'h86);
        chk({6'h0, o_lock_mode}, 8'h02);
        wr(UNM_A, 8'h55);
        chk({7'h0, o_wr_other}, 8'h01);
        wr(CFG_A, 8'h00);
        rd(CFG_A, 8'h01);
        wr(KEY_A, `IPL_KEY_FULL);
        wr(CFG_A, 8'h02);
        rd(CFG_A, 8'h02);
        // Mid-run reset from a locked state must reopen the lock
        wr(CFG_A, 8'h05);
        wr(KEY_A, 8'hFF);
        @(posedge i_ref_clk);
        i_rstn <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        rd(KEY_A, 8'h85);
        chk({6'h0, o_lock_mode}, 8'h01);
        rd(CFG_A, 8'h02);
        pin(1'b0, 8'h01);
        results();
    end
endmodule // tb_top
